//--- wdsel_pkg.sv
package wdsel_pkg;
    localparam int unsigned WDSEL_ADDR_W = 32;
    localparam int unsigned WDSEL_DATA_W = 32;
    // register byte offsets
    localparam logic [11:0] WDSEL_CTRL_OFS = 12'h000;
    localparam logic [11:0] WDSEL_STAT_OFS = 12'h004;
    localparam logic [11:0] WDSEL_IEN_OFS = 12'h008;
    localparam logic [11:0] WDSEL_ICLR_OFS = 12'h00C;
    localparam logic [11:0] WDSEL_OPT_OFS = 12'h010;
    // control fields
    localparam int unsigned WDSEL_CTRL_ACT_BIT = 0;
    localparam int unsigned WDSEL_CTRL_IEN_BIT = 1;
    // event status fields
    localparam int unsigned WDSEL_EV_RST_BIT = 0;
    localparam int unsigned WDSEL_EV_IRQ_BIT = 1;
    localparam int unsigned WDSEL_EV_DENY_BIT = 2;
    localparam int unsigned WDSEL_EV_W = 3;
    // option fields
    localparam int unsigned WDSEL_OPT_HWR_BIT = 0;
    localparam int unsigned WDSEL_OPT_HWI_BIT = 1;
    localparam int unsigned WDSEL_OPT_FMP_BIT = 2;
    localparam logic [1:0] WDSEL_CTRL_RST = 2'h0;
    localparam logic [WDSEL_EV_W-1:0] WDSEL_EV_RST = 3'h0;

    typedef enum logic [1:0] {
        WDSEL_ACT_NONE,
        WDSEL_ACT_RESET,
        WDSEL_ACT_IRQ
    } wdsel_action_e;

    // timeout outcome decode
    function automatic wdsel_action_e wdsel_decode(
        input logic hw_rst,
        input logic hw_irq,
        input logic act,
        input logic ien
    );
        wdsel_action_e r;
        r = WDSEL_ACT_NONE;
        if (hw_rst) begin
            r = WDSEL_ACT_RESET;
        end else if (act) begin
            r = WDSEL_ACT_RESET;
        end else if (hw_irq) begin
            r = WDSEL_ACT_IRQ;
        end else if (ien) begin
            r = WDSEL_ACT_IRQ;
        end
        return r;
    endfunction : wdsel_decode
endpackage : wdsel_pkg

//--- wdsel_sync.sv
`timescale 1ns/10ps
module wdsel_sync
    import wdsel_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // async level in, synced out
    input wire logic i_d,
    output logic o_q
);
    logic meta_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule : wdsel_sync

//--- wdsel_tb_top.sv
`timescale 1ns/10ps
module watchdog_timeout_action_select_tb_top;
    import wdsel_pkg::*;
    // option sets per instance: none, irq+protect, reset, reset+irq
    localparam logic [3:0] OPT_R = 4'b1100;
    localparam logic [3:0] OPT_I = 4'b1010;
    localparam logic [3:0] OPT_F = 4'b0010;
    logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite;
    logic [WDSEL_ADDR_W-1:0] i_paddr;
    logic [WDSEL_DATA_W-1:0] i_pwdata;
    logic i_wdog_timeout, i_readout_req;
    wire [3:0] pready, pslverr, sys_rst, top_level_irq, grant, deny, irq;
    wire [WDSEL_DATA_W-1:0] prdata [4];
    logic [130:0] note_q [$];
    logic [7:0] ev_q [$];
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] rnd;
    logic [127:0] e;
    logic [7:0] ev;
    logic [7:0] mon_ev;
    logic [1:0] c, m, a;
    for (genvar g = 0; g < 4; g++) begin : g_dut
        wdsel_top #(
            .HW_WDOG_RESET_OPTION(OPT_R[g]),
            .HW_WDOG_IRQ_OPTION(OPT_I[g]),
            .FULL_READOUT_PROTECT_OPTION(OPT_F[g])
        ) wdsel_top_inst (
            .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
            .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
            .i_pwdata(i_pwdata), .o_prdata(prdata[g]), .o_pready(pready[g]),
            .o_pslverr(pslverr[g]), .i_wdog_timeout(i_wdog_timeout),
            .i_readout_req(i_readout_req), .o_sys_reset(sys_rst[g]),
            .o_top_level_irq(top_level_irq[g]), .o_readout_grant(grant[g]),
            .o_readout_deny(deny[g]), .o_irq(irq[g])
        );
    end
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic check(input string name, input logic [127:0] exp,
                         input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    // expected outcome per instance, bit0 reset, bit1 interrupt
    function automatic logic [1:0] exp_act(input int g, input logic [1:0] cv);
        logic r;
        r = OPT_R[g] | cv[0];
        return {~r & (OPT_I[g] | cv[1]), r};
    endfunction : exp_act
    // one apb transfer; chk bit1 checks pslverr, bit0 checks data
    task automatic apb(input logic wr, input logic [11:0] ofs,
                       input logic [31:0] wd, input logic [127:0] exp,
                       input logic [1:0] chk, input logic err);
        @(posedge i_clk);
        note_q.push_back({chk, err, exp});
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {20'h0, ofs};
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready[0] !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // monitor: transfers and timeout outcomes
    always @(posedge i_clk) begin
        if (pready[0] === 1'b1) begin
            if (note_q.size() == 0) begin
                check("apb note", 128'h1, 128'h0);
            end else begin
                if (note_q[0][130]) begin
                    check("pslverr", {4{note_q[0][128]}}, pslverr);
                end
                if (note_q[0][129]) begin
                    check("prdata", note_q[0][127:0],
                        {prdata[3], prdata[2], prdata[1], prdata[0]});
                end
                void'(note_q.pop_front());
            end
        end
        if (|{top_level_irq, sys_rst}) begin
            mon_ev = (ev_q.size() > 0) ? ev_q.pop_front() : 8'h0;
            check("outcome", mon_ev,
                {top_level_irq, sys_rst});
        end
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        i_rst_n = 1'b0;
        {i_psel, i_penable, i_pwrite, i_wdog_timeout, i_readout_req} = 5'h0;
        i_paddr = 32'h0;
        i_pwdata = 32'h0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        check("outputs", 128'h0, {sys_rst, top_level_irq, grant, deny, irq, pready});
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0, 128'h0, 2'h3, 1'b0);
        end
        for (int g = 0; g < 4; g++) begin
            e[g*32 +: 32] = {29'h0, OPT_F[g], OPT_I[g], OPT_R[g]};
        end
        apb(1'b0, WDSEL_OPT_OFS, 32'h0, e, 2'h3, 1'b0);
        apb(1'b1, WDSEL_OPT_OFS, 32'hFFFFFFFF, 128'h0, 2'h0, 1'b0);
        apb(1'b0, WDSEL_OPT_OFS, 32'h0, e, 2'h3, 1'b0);
        apb(1'b0, 12'h014, 32'h0, 128'h0, 2'h3, 1'b1);
        rnd = 8'h40;
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            c = (k < 4) ? k[1:0] : rnd[1:0];
            m = rnd[3:2];
            apb(1'b1, WDSEL_CTRL_OFS, {30'h0, c}, 128'h0, 2'h2, 1'b0);
            apb(1'b1, WDSEL_IEN_OFS, {30'h0, m}, 128'h0, 2'h2, 1'b0);
            for (int g = 0; g < 4; g++) begin
                a = exp_act(g, c);
                {ev[4+g], ev[g]} = a;
                e[g*32 +: 32] = {30'h0, a};
            end
            ev_q.push_back(ev);
            i_wdog_timeout <= 1'b1;
            repeat (3) @(posedge i_clk);
            i_wdog_timeout <= 1'b0;
            repeat (6) @(posedge i_clk);
            apb(1'b0, WDSEL_STAT_OFS, 32'h0, e, 2'h3, 1'b0);
            @(negedge i_clk);
            for (int g = 0; g < 4; g++) begin
                check("irq", {127'h0, |(e[g*32 +: 2] & m)}, {127'h0, irq[g]});
            end
            apb(1'b1, WDSEL_ICLR_OFS, 32'h7, 128'h0, 2'h2, 1'b0);
            repeat (2) @(negedge i_clk);
            check("irq clear", 128'h0, {124'h0, irq});
        end
        @(posedge i_clk);
        i_readout_req <= 1'b1;
        repeat (6) @(negedge i_clk);
        check("grant", {124'h0, ~OPT_F}, {124'h0, grant});
        check("deny", {124'h0, OPT_F}, {124'h0, deny});
        for (int g = 0; g < 4; g++) e[g*32 +: 32] = {29'h0, OPT_F[g], 2'h0};
        apb(1'b0, WDSEL_STAT_OFS, 32'h0, e, 2'h3, 1'b0);
        i_readout_req <= 1'b0;
        repeat (4) @(posedge i_clk);
        wrap_up();
    end
endmodule : watchdog_timeout_action_select_tb_top

//--- wdsel_top.sv
`timescale 1ns/10ps
module wdsel_top
    import wdsel_pkg::*;
#(
    // manufacture constants
    parameter bit HW_WDOG_RESET_OPTION = 1'b0,
    parameter bit HW_WDOG_IRQ_OPTION = 1'b0,
    parameter bit FULL_READOUT_PROTECT_OPTION = 1'b0
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [WDSEL_ADDR_W-1:0] i_paddr,
    input wire logic [WDSEL_DATA_W-1:0] i_pwdata,
    output logic [WDSEL_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // watchdog timeout and external readout request
    input wire logic i_wdog_timeout,
    input wire logic i_readout_req,
    // outcomes
    output logic o_sys_reset,
    output logic o_top_level_irq,
    output logic o_readout_grant,
    output logic o_readout_deny,
    output logic o_irq
);
    // option constants, never writable
    localparam logic hw_wdog_reset_option = HW_WDOG_RESET_OPTION;
    localparam logic hw_wdog_irq_option = HW_WDOG_IRQ_OPTION;
    localparam logic full_readout_protect_option =
        FULL_READOUT_PROTECT_OPTION;

    logic timeout_s;
    logic readout_s;
    logic timeout_prev_q;
    logic [1:0] wdog_control_status_q;
    logic [WDSEL_EV_W-1:0] stat_q;
    logic [WDSEL_EV_W-1:0] ien_q;
    logic [WDSEL_EV_W-1:0] ev_d;
    logic timeout_pulse;
    wdsel_action_e action;
    logic wr_en;
    logic rd_en;
    logic [11:0] ofs;
    logic hit;

    // pin synchronisers
    wdsel_sync u_sync_timeout (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_wdog_timeout),
        .o_q(timeout_s)
    );
    wdsel_sync u_sync_readout (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_readout_req),
        .o_q(readout_s)
    );

    // timeout edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            timeout_prev_q <= 1'b0;
        end else begin
            timeout_prev_q <= timeout_s;
        end
    end
    assign timeout_pulse = timeout_s & ~timeout_prev_q;

    assign action = wdsel_decode(hw_wdog_reset_option, hw_wdog_irq_option,
        wdog_control_status_q[WDSEL_CTRL_ACT_BIT],
        wdog_control_status_q[WDSEL_CTRL_IEN_BIT]);

    // outcome pulses
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sys_reset <= 1'b0;
            o_top_level_irq <= 1'b0;
        end else begin
            o_sys_reset <= timeout_pulse
                && (action == WDSEL_ACT_RESET);
            o_top_level_irq <= timeout_pulse
                && (action == WDSEL_ACT_IRQ);
        end
    end

    // readout gate
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_readout_grant <= 1'b0;
            o_readout_deny <= 1'b0;
        end else begin
            o_readout_grant <= readout_s
                & ~full_readout_protect_option;
            o_readout_deny <= readout_s
                & full_readout_protect_option;
        end
    end

    // apb decode
    assign ofs = i_paddr[11:0];
    assign wr_en = i_psel & i_penable & i_pwrite;
    assign rd_en = i_psel & ~i_penable & ~i_pwrite;
    always_comb begin
        hit = 1'b0;
        if (i_paddr[WDSEL_ADDR_W-1:12] != 20'h00000) begin
            hit = 1'b0;
        end else if (ofs == WDSEL_CTRL_OFS) begin
            hit = 1'b1;
        end else if (ofs == WDSEL_STAT_OFS) begin
            hit = 1'b1;
        end else if (ofs == WDSEL_IEN_OFS) begin
            hit = 1'b1;
        end else if (ofs == WDSEL_ICLR_OFS) begin
            hit = 1'b1;
        end else if (ofs == WDSEL_OPT_OFS) begin
            hit = 1'b1;
        end
    end

    // control register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wdog_control_status_q <= WDSEL_CTRL_RST;
        end else if (wr_en && hit && ofs == WDSEL_CTRL_OFS) begin
            wdog_control_status_q <= i_pwdata[1:0];
        end
    end

    // irq enable register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ien_q <= WDSEL_EV_RST;
        end else if (wr_en && hit && ofs == WDSEL_IEN_OFS) begin
            ien_q <= i_pwdata[WDSEL_EV_W-1:0];
        end
    end

    // sticky status, set beats clear
    always_comb begin
        ev_d = WDSEL_EV_RST;
        ev_d[WDSEL_EV_RST_BIT] = timeout_pulse && (action == WDSEL_ACT_RESET);
        ev_d[WDSEL_EV_IRQ_BIT] = timeout_pulse && (action == WDSEL_ACT_IRQ);
        ev_d[WDSEL_EV_DENY_BIT] = readout_s & full_readout_protect_option;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stat_q <= WDSEL_EV_RST;
        end else if (wr_en && hit && ofs == WDSEL_ICLR_OFS) begin
            stat_q <= (stat_q & ~i_pwdata[WDSEL_EV_W-1:0]) | ev_d;
        end else begin
            stat_q <= stat_q | ev_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_q & ien_q);
        end
    end

    // read data captured in setup, answer in access
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata <= '0;
        end else if (rd_en && !hit) begin
            o_prdata <= '0;
        end else if (rd_en) begin
            o_prdata <= '0;
            if (ofs == WDSEL_CTRL_OFS) begin
                o_prdata[1:0] <= wdog_control_status_q;
            end else if (ofs == WDSEL_STAT_OFS) begin
                o_prdata[WDSEL_EV_W-1:0] <= stat_q;
            end else if (ofs == WDSEL_IEN_OFS) begin
                o_prdata[WDSEL_EV_W-1:0] <= ien_q;
            end else if (ofs == WDSEL_OPT_OFS) begin
                o_prdata[WDSEL_OPT_HWR_BIT] <= hw_wdog_reset_option;
                o_prdata[WDSEL_OPT_HWI_BIT] <= hw_wdog_irq_option;
                o_prdata[WDSEL_OPT_FMP_BIT] <= full_readout_protect_option;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~hit;
        end
    end

    // checks
    property p_reset_opt;
        @(posedge i_clk) disable iff (!i_rst_n)
        (timeout_pulse && hw_wdog_reset_option) |=> o_sys_reset;
    endproperty
    a_reset_opt: assert property (p_reset_opt)
        else $error("reset option timeout gave no reset");

    property p_act_reset;
        @(posedge i_clk) disable iff (!i_rst_n)
        (timeout_pulse && wdog_control_status_q[WDSEL_CTRL_ACT_BIT])
        |=> (o_sys_reset && !o_top_level_irq);
    endproperty
    a_act_reset: assert property (p_act_reset)
        else $error("activation timeout gave no reset");

    property p_irq_opt;
        @(posedge i_clk) disable iff (!i_rst_n)
        (timeout_pulse && !hw_wdog_reset_option && hw_wdog_irq_option
         && !wdog_control_status_q[WDSEL_CTRL_ACT_BIT]) |=> o_top_level_irq;
    endproperty
    a_irq_opt: assert property (p_irq_opt)
        else $error("irq option timeout gave no irq");

    property p_excl;
        @(posedge i_clk) disable iff (!i_rst_n)
        !(o_sys_reset && o_top_level_irq);
    endproperty
    a_excl: assert property (p_excl)
        else $error("reset and irq together");

    property p_deny;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_readout_grant |-> !full_readout_protect_option;
    endproperty
    a_deny: assert property (p_deny)
        else $error("readout granted while protected");

    property p_none;
        @(posedge i_clk) disable iff (!i_rst_n)
        (timeout_pulse && !hw_wdog_reset_option && !hw_wdog_irq_option
         && wdog_control_status_q == 2'h0)
        |=> (!o_sys_reset && !o_top_level_irq);
    endproperty
    a_none: assert property (p_none)
        else $error("idle decode produced an outcome");

    property p_ien_irq;
        @(posedge i_clk) disable iff (!i_rst_n)
        (timeout_pulse && !hw_wdog_reset_option && !hw_wdog_irq_option
         && wdog_control_status_q == 2'h2) |=> o_top_level_irq;
    endproperty
    a_ien_irq: assert property (p_ien_irq)
        else $error("enabled irq timeout gave no irq");

    property p_opt_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        (rd_en && hit && ofs == WDSEL_OPT_OFS)
        |=> o_prdata[WDSEL_OPT_FMP_BIT] == full_readout_protect_option;
    endproperty
    a_opt_read: assert property (p_opt_read)
        else $error("option readback wrong");

    property p_both_opt;
        @(posedge i_clk) disable iff (!i_rst_n)
        (timeout_pulse && hw_wdog_reset_option && hw_wdog_irq_option)
        |=> (o_sys_reset && !o_top_level_irq);
    endproperty
    a_both_opt: assert property (p_both_opt)
        else $error("reset lost priority over irq");

    property p_deny_out;
        @(posedge i_clk) disable iff (!i_rst_n)
        (readout_s && full_readout_protect_option)
        |=> (o_readout_deny && !o_readout_grant);
    endproperty
    a_deny_out: assert property (p_deny_out)
        else $error("protected readout not refused");

    property p_grant_out;
        @(posedge i_clk) disable iff (!i_rst_n)
        (readout_s && !full_readout_protect_option) |=> o_readout_grant;
    endproperty
    a_grant_out: assert property (p_grant_out)
        else $error("unprotected readout not granted");

    property p_quiet;
        @(posedge i_clk) disable iff (!i_rst_n)
        !timeout_pulse |=> (!o_sys_reset && !o_top_level_irq);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("outcome without a timeout");

    property p_irq_level;
        @(posedge i_clk) disable iff (!i_rst_n)
        (|(stat_q & ien_q)) |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("enabled status gave no irq");

    property p_pready;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_psel && !i_penable) |=> o_pready;
    endproperty
    a_pready: assert property (p_pready)
        else $error("setup cycle not answered");
endmodule : wdsel_top
